// *** design/memc_cycle_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "memc_cycle_defines.svh"

// What this block does
// - ready reply: wait, address hold and last lines all low
// - wait reply: wait line high, address hold and last low
// - address hold reply: wait and hold high; host keeps address stable
// - last reply line is always low
// - system bus data width fixed at 32 bits
// - no sequential transfers on the system bus
// - every access opens with a start state on bus cycle start
// - two basic states, optional address setup wait, general waits
// - SDRAM activate, read and precharge each have their own state
// - bank cycle wait setting 2 or 3 adds wait after the activate command
// - latency waits follow a read command until data valid
// - SDRAM write: write command, post-write precharge, end-of-write
// - flyby DMA between SDRAM and I/O uses its own state
// - pending state while waiting to generate the next cycle
// - flyby cycles identical on system and local bus
// - two-cycle DMA uses a 32-bit local bus
// - four-word SDRAM two-cycle timing ignores speculative read
module memc_cycle_ctrl
    import memc_cycle_pkg::*;
#(
    parameter int DATA_W = `SYS_BUS_WIDTH,
    parameter int CNT_W  = 4
) (
    // clock and reset
    input  wire logic              core_clk_in,
    input  wire logic              rst_in,
    // processor system bus request
    input  wire logic              cycle_start_in,
    input  wire logic              write_in,
    input  wire logic [1:0]        mem_kind_in,
    input  wire logic              flyby_in,
    input  wire logic              spec_read_in,
    input  wire logic              mem_busy_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    // configuration
    input  wire logic [1:0]        bank_cycle_wait_setting_in,
    input  wire logic [CNT_W-1:0]  setup_waits_in,
    input  wire logic [CNT_W-1:0]  data_waits_in,
    input  wire logic [CNT_W-1:0]  cas_latency_in,
    // local memory bus
    input  wire logic [DATA_W-1:0] mem_rdata_in,
    // reply lines
    output logic                   wait_reply_line_out,
    output logic                   address_hold_reply_line_out,
    output logic                   last_reply_line_out,
    output logic [DATA_W-1:0]      rdata_out,
    // local side
    output logic [2:0]             sdram_cmd_out,
    output logic                   mem_write_out,
    output logic                   flyby_ack_out,
    output logic [DATA_W-1:0]      mem_wdata_out,
    output logic [15:0]            state_out
);

    // =================================================================
    // state and access capture
    cycle_state_t      state_ff;
    cycle_state_t      nxt_state;
    logic              write_ff;
    logic [1:0]        kind_ff;
    logic              flyby_ff;
    logic              bcw_on;
    logic              cnt_load;
    logic [CNT_W-1:0]  cnt_value;
    logic              cnt_done;
    logic              reply_ready;
    logic              reply_ahold;
    logic [2:0]        reply_code;

    assign bcw_on = (bank_cycle_wait_setting_in >= `BCW_INSERT_MIN);

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            write_ff <= 1'b0;
            kind_ff  <= 2'h0;
            flyby_ff <= 1'b0;
        end else if (state_ff == ST_START) begin
            write_ff <= write_in;
            kind_ff  <= mem_kind_in;
            // speculative read is not looked at: timing is fixed for flyby
            flyby_ff <= flyby_in;
        end
    end

    // =================================================================
    // wait counter shared by setup, data, latency waits
    memc_wait_counter #(
        .W(CNT_W)
    ) u_wait (
        .clk_in   (core_clk_in),
        .rst_in   (rst_in),
        .load_in  (cnt_load),
        .value_in (cnt_value),
        .step_in  (1'b1),
        .done_out (cnt_done)
    );

    // =================================================================
    // next state
    always_comb begin
        nxt_state = state_ff;
        cnt_load  = 1'b0;
        cnt_value = '0;
        unique case (state_ff)
            ST_IDLE: begin
                if (cycle_start_in) begin
                    nxt_state = ST_START;
                end
            end
            ST_START: begin
                if (mem_busy_in) begin
                    nxt_state = ST_PEND;
                end else if (flyby_in && mem_kind_in == MEM_SDRAM) begin
                    nxt_state = ST_ACT;
                end else if (mem_kind_in == MEM_SDRAM) begin
                    nxt_state = ST_ACT;
                end else if (setup_waits_in != '0) begin
                    nxt_state = ST_ASETUP;
                    cnt_load  = 1'b1;
                    cnt_value = setup_waits_in - CNT_W'(1);
                end else begin
                    nxt_state = ST_BASIC1;
                end
            end
            ST_PEND: begin
                if (!mem_busy_in) begin
                    nxt_state = (kind_ff == MEM_SDRAM) ? ST_ACT : ST_BASIC1;
                end
            end
            ST_ASETUP: begin
                if (cnt_done) begin
                    nxt_state = ST_BASIC1;
                end
            end
            ST_BASIC1: begin
                nxt_state = ST_BASIC2;
                cnt_load  = 1'b1;
                cnt_value = data_waits_in;
            end
            ST_BASIC2: begin
                if (!cnt_done) begin
                    nxt_state = ST_WAIT;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (cnt_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_ACT: begin
                if (bcw_on) begin
                    nxt_state = ST_BCW;
                end else if (flyby_ff) begin
                    nxt_state = ST_FLYBY;
                end else begin
                    nxt_state = write_ff ? ST_WRCMD : ST_READ;
                end
            end
            ST_BCW: begin
                if (flyby_ff) begin
                    nxt_state = ST_FLYBY;
                end else begin
                    nxt_state = write_ff ? ST_WRCMD : ST_READ;
                end
            end
            ST_READ: begin
                nxt_state = ST_LATE;
                cnt_load  = 1'b1;
                cnt_value = (cas_latency_in > CNT_W'(1)) ?
                            cas_latency_in - CNT_W'(2) : '0;
            end
            ST_LATE: begin
                if (cnt_done) begin
                    nxt_state = ST_PREC;
                end
            end
            ST_PREC: begin
                nxt_state = ST_IDLE;
            end
            ST_WRCMD: begin
                nxt_state = ST_POST_WRITE_PRECHARGE_STATE;
            end
            ST_POST_WRITE_PRECHARGE_STATE: begin
                nxt_state = ST_WRITE_END_STATE;
            end
            ST_WRITE_END_STATE: begin
                nxt_state = ST_IDLE;
            end
            ST_FLYBY: begin
                nxt_state = ST_PREC;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // =================================================================
    // reply lines; ready when the next state ends the cycle
    assign reply_ready = (state_ff != ST_IDLE) && (nxt_state == ST_IDLE);
    // hold address while the memory side cannot start the cycle yet
    assign reply_ahold = (nxt_state == ST_PEND);

    memc_reply_encoder u_reply (
        .ready_in (reply_ready),
        .ahold_in (reply_ahold),
        .code_out (reply_code)
    );

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_reply_line_out         <= 1'b0;
            address_hold_reply_line_out <= 1'b0;
            last_reply_line_out         <= 1'b0;
        end else if (nxt_state == ST_IDLE && state_ff == ST_IDLE) begin
            wait_reply_line_out         <= 1'b0;
            address_hold_reply_line_out <= 1'b0;
            last_reply_line_out         <= 1'b0;
        end else begin
            wait_reply_line_out         <= reply_code[2];
            address_hold_reply_line_out <= reply_code[1];
            last_reply_line_out         <= 1'b0;
        end
    end

    // =================================================================
    // local side outputs
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sdram_cmd_out <= SD_NOP;
        end else begin
            unique case (nxt_state)
                ST_ACT:   sdram_cmd_out <= SD_ACT;
                ST_READ:  sdram_cmd_out <= SD_READ;
                ST_PREC:  sdram_cmd_out <= SD_PRE;
                ST_POST_WRITE_PRECHARGE_STATE:  sdram_cmd_out <= SD_PRE;
                ST_WRCMD: sdram_cmd_out <= SD_WR;
                default:  sdram_cmd_out <= SD_NOP;
            endcase
        end
    end

    // data paths are single 32-bit words: no sequential bursts
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_write_out <= 1'b0;
            flyby_ack_out <= 1'b0;
            mem_wdata_out <= '0;
            rdata_out     <= '0;
            state_out     <= ST_IDLE;
        end else begin
            // write flag is only latched when leaving the start state
            mem_write_out <= (nxt_state == ST_WRCMD) ||
                             (nxt_state == ST_BASIC1 &&
                              ((state_ff == ST_START) ? write_in : write_ff));
            flyby_ack_out <= (nxt_state == ST_FLYBY);
            mem_wdata_out <= wdata_in;
            if (state_ff == ST_LATE && cnt_done) begin
                rdata_out <= mem_rdata_in;
            end else if ((state_ff == ST_BASIC2 || state_ff == ST_WAIT) &&
                         cnt_done && !write_ff) begin
                rdata_out <= mem_rdata_in;
            end
            state_out <= nxt_state;
        end
    end

    // =================================================================
    // checks
    reply_codes_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        {wait_reply_line_out, address_hold_reply_line_out, last_reply_line_out}
        inside {`REPLY_READY, `REPLY_WAIT, `REPLY_AHOLD})
        else $error("illegal reply code");
    last_low_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !last_reply_line_out)
        else $error("last reply driven");
    start_first_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_IDLE && cycle_start_in |=> state_ff == ST_START)
        else $error("no start state");
    read_late_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_READ |=> state_ff == ST_LATE)
        else $error("no latency state");
    write_seq_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_WRCMD |=> state_ff == ST_POST_WRITE_PRECHARGE_STATE ##1 state_ff == ST_WRITE_END_STATE)
        else $error("write sequence broken");
    bcw_ins_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_ACT && bcw_on |=> state_ff == ST_BCW)
        else $error("bank wait missing");
    nobcw_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_ACT && !bcw_on |=> state_ff != ST_BCW)
        else $error("bank wait unexpected");
    pend_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_START && mem_busy_in |=> state_ff == ST_PEND
        ##0 address_hold_reply_line_out && wait_reply_line_out)
        else $error("pending hold missing");
    ready_end_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_WRITE_END_STATE |=> !wait_reply_line_out && !address_hold_reply_line_out)
        else $error("ready missing");
    flyby_ack_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_FLYBY |-> flyby_ack_out)
        else $error("flyby ack missing");

    rd_cov_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_READ ##1 state_ff == ST_LATE);
    wr_cov_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_WRITE_END_STATE);
    fly_cov_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_FLYBY);
    pend_cov_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
        state_ff == ST_PEND);

endmodule : memc_cycle_ctrl
`default_nettype wire

// *** design/memc_cycle_defines.svh ***
`ifndef MEMC_CYCLE_DEFINES_SVH
`define MEMC_CYCLE_DEFINES_SVH

// =====================================================================
// reply line encodings {wait, address hold, last}
`define REPLY_READY        3'h0
`define REPLY_WAIT         3'h4
`define REPLY_AHOLD        3'h6

// =====================================================================
// bank cycle wait setting thresholds and defaults
`define BCW_INSERT_MIN     2'h2
`define SYS_BUS_WIDTH      32
`define LOCAL_BUS_WIDTH    32
`define DEF_SETUP_WAITS    4'h1
`define DEF_DATA_WAITS     4'h0
`define DEF_CAS_LATENCY    4'h2

`endif

// *** design/memc_cycle_pkg.sv ***
package memc_cycle_pkg;

    typedef enum logic [15:0] {
        ST_IDLE    = 16'h0001,
        ST_START   = 16'h0002,
        ST_BASIC1  = 16'h0004,
        ST_BASIC2  = 16'h0008,
        ST_ASETUP  = 16'h0010,
        ST_WAIT    = 16'h0020,
        ST_ACT     = 16'h0040,
        ST_BCW     = 16'h0080,
        ST_READ    = 16'h0100,
        ST_LATE    = 16'h0200,
        ST_PREC    = 16'h0400,
        ST_WRCMD   = 16'h0800,
        ST_POST_WRITE_PRECHARGE_STATE    = 16'h1000,
        ST_WRITE_END_STATE    = 16'h2000,
        ST_FLYBY   = 16'h4000,
        ST_PEND    = 16'h8000
    } cycle_state_t;

    typedef enum logic [2:0] {
        SD_NOP  = 3'h0,
        SD_ACT  = 3'h1,
        SD_READ = 3'h2,
        SD_WR   = 3'h3,
        SD_PRE  = 3'h4
    } sdram_cmd_t;

    typedef enum logic [1:0] {
        MEM_SRAM  = 2'h0,
        MEM_SDRAM = 2'h1,
        MEM_ROM   = 2'h2
    } mem_kind_t;

endpackage : memc_cycle_pkg

// *** design/memc_wait_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
// loadable down counter; done is high while count is zero
module memc_wait_counter #(
    parameter int W = 4
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] value_in,
    input  wire logic         step_in,
    output logic              done_out
);
    logic [W-1:0] count_ff;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_ff <= '0;
        end else if (load_in) begin
            count_ff <= value_in;
        end else if (step_in && count_ff != '0) begin
            count_ff <= count_ff - W'(1);
        end
    end

    assign done_out = (count_ff == '0);
endmodule : memc_wait_counter
`default_nettype wire

// *** design/memc_reply_encoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "memc_cycle_defines.svh"
// maps reply kind onto the three reply lines; only three legal codes exist
module memc_reply_encoder (
    input  wire logic       ready_in,
    input  wire logic       ahold_in,
    output logic [2:0]      code_out
);
    always_comb begin
        if (ready_in) begin
            code_out = `REPLY_READY;
        end else if (ahold_in) begin
            code_out = `REPLY_AHOLD;
        end else begin
            code_out = `REPLY_WAIT;
        end
    end
endmodule : memc_reply_encoder
`default_nettype wire

// *** dv/memc_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// cpu core side: one single 32-bit word per bus cycle
module memc_cpu_model
    import memc_cycle_pkg::*;
(
    // clock
    input  wire logic        core_clk_in,
    // reply side
    input  wire logic        wait_in,
    input  wire logic        hold_in,
    input  wire logic        last_in,
    input  wire logic [15:0] state_in,
    // request side
    output logic             start_out,
    output logic             write_out,
    output logic [1:0]       kind_out,
    output logic             flyby_out,
    output logic             spec_out,
    output logic [31:0]      wdata_out
);
    initial begin
        start_out = 1'b0;
        write_out = 1'b0;
        kind_out  = 2'h0;
        flyby_out = 1'b0;
        spec_out  = 1'b0;
        wdata_out = 32'h0;
    end

    // called just after a falling edge; qualifiers stay put through wait and hold
    task automatic xfer(input logic w, input logic [1:0] k, input logic f,
                        input logic [31:0] d, output int n);
        start_out = 1'b1;
        write_out = w;
        kind_out  = k;
        flyby_out = f;
        spec_out  = 1'($urandom_range(1, 0));
        wdata_out = d;
        n = 0;
        do begin
            @(negedge core_clk_in);
            n++;
            // start is a strobe: a level still high in the ready cycle opens a second cycle
            if (state_in !== ST_IDLE) start_out = 1'b0;
        end while (!(state_in === ST_IDLE && {wait_in, hold_in, last_in} === 3'h0) && n < 500);
        // let the edge that samples ready pass before anything changes
        @(negedge core_clk_in);
    endtask : xfer

    // released data no longer shows the last word
    task automatic stop();
        start_out = 1'b0;
        wdata_out = ~wdata_out;
    endtask : stop
endmodule : memc_cpu_model
`default_nettype wire

// *** dv/memc_response_and_cycle_states_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module memc_response_and_cycle_states_tb
    import memc_cycle_pkg::*;
;
    logic        core_clk_in, rst_in, cycle_start_in, write_in, flyby_in, spec_read_in;
    logic        mem_busy_in, wait_l, hold_l, last_l, mem_write_out, flyby_ack_out;
    logic [1:0]  mem_kind_in, bank_cycle_wait_setting_in;
    logic [3:0]  setup_waits_in, data_waits_in, cas_latency_in;
    logic [31:0] wdata_in, mem_rdata_in, rdata_out, mem_wdata_out;
    logic [2:0]  sdram_cmd_out;
    logic [15:0] state_out, mask;
    logic [7:0]  cmdm;
    logic        ack, mw, prev_busy;
    int          error_cnt, checks_done, len, rdy, wt, hd, badc;

    memc_cycle_ctrl memc_cycle_ctrl_i (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .cycle_start_in(cycle_start_in),
        .write_in(write_in), .mem_kind_in(mem_kind_in), .flyby_in(flyby_in),
        .spec_read_in(spec_read_in), .mem_busy_in(mem_busy_in), .wdata_in(wdata_in),
        .bank_cycle_wait_setting_in(bank_cycle_wait_setting_in),
        .setup_waits_in(setup_waits_in), .data_waits_in(data_waits_in),
        .cas_latency_in(cas_latency_in), .mem_rdata_in(mem_rdata_in),
        .wait_reply_line_out(wait_l), .address_hold_reply_line_out(hold_l),
        .last_reply_line_out(last_l), .rdata_out(rdata_out), .sdram_cmd_out(sdram_cmd_out),
        .mem_write_out(mem_write_out), .flyby_ack_out(flyby_ack_out),
        .mem_wdata_out(mem_wdata_out), .state_out(state_out));

    memc_cpu_model memc_cpu_model_i (
        .core_clk_in(core_clk_in), .wait_in(wait_l), .hold_in(hold_l), .last_in(last_l),
        .state_in(state_out), .start_out(cycle_start_in), .write_out(write_in),
        .kind_out(mem_kind_in), .flyby_out(flyby_in), .spec_out(spec_read_in),
        .wdata_out(wdata_in));

    initial core_clk_in = 1'b0;
    always #20 core_clk_in = ~core_clk_in;

    // =====================================================================
    // monitor of one bus cycle, sampled mid-period
    always @(negedge core_clk_in) begin
        // lines are registered from the next state, so ready stands in the first idle cycle
        if (state_out === ST_IDLE && prev_busy === 1'b1 && {wait_l, hold_l, last_l} === 3'h0)
            rdy++;
        prev_busy = (state_out !== ST_IDLE);
        if (state_out !== ST_IDLE) begin
            mask = mask | state_out;
            len++;
            if ({wait_l, hold_l, last_l} === 3'h0) badc++;
            if ({wait_l, hold_l, last_l} === 3'h4) wt++;
            if ({wait_l, hold_l, last_l} === 3'h6) hd++;
            if (last_l !== 1'b0 || (wait_l !== 1'b1 && hold_l !== 1'b0)) badc++;
            if (len > 1 && mem_wdata_out !== wdata_in) badc++;
            if (sdram_cmd_out != 3'h0) cmdm[sdram_cmd_out] = 1'b1;
            ack = ack | flyby_ack_out;
            mw  = mw | mem_write_out;
        end
    end

    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk

    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    task automatic cfg(input int b, input int s, input int d, input int c);
        bank_cycle_wait_setting_in = 2'(b);
        setup_waits_in             = 4'(s);
        data_waits_in              = 4'(d);
        cas_latency_in             = 4'(c);
    endtask : cfg

    // one transfer; expectations worked out from the configuration in force
    task automatic one(input logic w, input logic [1:0] k, input logic f, input logic bz);
        logic [15:0] em;
        logic [7:0]  ec;
        logic [31:0] rd;
        int          el, b, lat, n;
        rd = $urandom;
        mem_rdata_in = rd;
        mask = 16'h0; cmdm = 8'h0; ack = 1'b0; mw = 1'b0;
        len = 0; rdy = 0; wt = 0; hd = 0; badc = 0;
        b = (bank_cycle_wait_setting_in >= 2'h2);
        lat = (cas_latency_in > 4'h1) ? int'(cas_latency_in) - 1 : 1;
        em = ST_START | (b != 0 ? ST_BCW : 16'h0);
        if (k == MEM_SDRAM) em = em | ST_ACT;
        if (k != MEM_SDRAM) begin
            em = ST_START | ST_BASIC1 | ST_BASIC2;
            if (setup_waits_in != 4'h0) em = em | ST_ASETUP;
            if (data_waits_in != 4'h0) em = em | ST_WAIT;
            el = 3 + int'(setup_waits_in) + int'(data_waits_in); ec = 8'h00;
        end else if (f) begin
            em = em | ST_FLYBY | ST_PREC; el = 4 + b; ec = 8'h12;
        end else if (w) begin
            em = em | ST_WRCMD | ST_POST_WRITE_PRECHARGE_STATE | ST_WRITE_END_STATE; el = 5 + b; ec = 8'h1A;
        end else begin
            em = em | ST_READ | ST_LATE | ST_PREC; el = 4 + b + lat; ec = 8'h16;
        end
        mem_busy_in = bz;
        fork
            memc_cpu_model_i.xfer(w, k, f, $urandom, n);
            if (bz) begin
                repeat (4) @(negedge core_clk_in);
                mem_busy_in = 1'b0;
            end
        join
        chk(n < 500 && rdy == 1 && badc == 0, "reply codes");
        if (bz) begin
            chk(mask[15] === 1'b1 && hd > 0 && len > el, "pending hold");
        end else begin
            chk(len == el && mask === em, "state sequence");
            chk(wt == el && hd == 0, "wait replies");
            chk(cmdm === ec && ack === f, "commands or flyby");
        end
        if (!w && !f) chk(rdata_out === rd, "read data");
        chk(mw === (w && !f), "memory write");
    endtask : one

    // =====================================================================
    initial begin
        void'($urandom(32'h5FEC));
        rst_in = 1'b1; mem_busy_in = 1'b0; mem_rdata_in = 32'h0;
        cfg(0, 0, 0, 0);
        error_cnt = 0; checks_done = 0;
        repeat (10) @(negedge core_clk_in);
        chk(state_out === 16'h0001 && {wait_l, hold_l, last_l} === 3'h0, "reset state");
        rst_in = 1'b0;
        // every bank wait setting, latency boundaries, back to back
        for (int i = 0; i < 4; i++) begin
            cfg(i, 0, 0, i);
            one(1'b0, MEM_SDRAM, 1'b0, 1'b0);
            one(1'b1, MEM_SDRAM, 1'b0, 1'b0);
            one(1'b0, MEM_SDRAM, 1'b1, 1'b0);
        end
        cfg(0, 3, 3, 2);
        one(1'b0, MEM_SRAM, 1'b0, 1'b0);
        one(1'b1, MEM_ROM, 1'b0, 1'b0);
        for (int i = 0; i < 80; i++) begin
            logic [1:0] k;
            logic       f;
            k = 2'($urandom_range(2, 0));
            f = (k == MEM_SDRAM) ? 1'($urandom_range(1, 0)) : 1'b0;
            cfg($urandom_range(3, 0), $urandom_range(3, 0), $urandom_range(3, 0),
                $urandom_range(4, 1));
            one(f ? 1'b0 : 1'($urandom_range(1, 0)), k, f, 1'b0);
        end
        cfg(0, 0, 0, 2);
        one(1'b0, MEM_SRAM, 1'b0, 1'b1);
        memc_cpu_model_i.stop();
        repeat (3) @(negedge core_clk_in);
        chk(state_out === ST_IDLE, "idle after run");
        print_verdict();
    end

    // generous span: roughly thirty times the expected run
    initial begin
        #1000000;
        error_cnt++;
        print_verdict();
    end
endmodule : memc_response_and_cycle_states_tb
`default_nettype wire
